// ===== rtl/pfe_erase_ctrl.v
// host-side erase sequencer with toggle-bit completion polling
`timescale 1ns/1ns
`default_nettype none
`include "pfe_flash_regs.vh"

// Functional notes
// [RULE1] output enable stays high whenever write strobe and chip select are low
// [RULE2] chip erase confirm cycle goes to the fixed command address
// [RULE3] sector erase confirm cycle carries the chosen sector select address
// [RULE4] confirm data is 10h for chip erase, 30h for sector erase
// [RULE5] device advances toggle status on each output or chip enable toggle
// [RULE6] toggle bit level at start and end is arbitrary; only changes count
// [RULE7] all polling reads use one constant address
// [RULE8] only the low data byte carries command codes; upper byte driven zero
// [RULE9] bottom-boot sector addresses 02xxx, 04xxx, 06xxx and fexxx; the code uses 7e000 for the last one
// [RULE10] toggle bit inverts per read while busy, then stops changing
module pfe_erase_ctrl (
    input  wire                    clock,
    input  wire                    sys_rst,
    input  wire                    erase_start,
    input  wire                    erase_chip,
    input  wire [1:0]              sector_sel,
    input  wire [`PFE_DATA_W-1:0]  flash_dq_i,
    output wire [`PFE_ADDR_W-1:0]  flash_addr,
    output wire [`PFE_DATA_W-1:0]  flash_dq_o,
    output wire                    flash_dq_oe,
    output wire                    flash_ce_n,
    output wire                    flash_oe_n,
    output wire                    flash_we_n,
    output wire                    erase_ready,
    output reg                     erase_busy,
    output reg                     erase_done
);

    localparam [5:0] ST_IDLE  = 6'b00_0001;
    localparam [5:0] ST_ISSUE = 6'b00_0010;
    localparam [5:0] ST_WAIT  = 6'b00_0100;
    localparam [5:0] ST_POLL1 = 6'b00_1000;
    localparam [5:0] ST_POLL2 = 6'b01_0000;
    localparam [5:0] ST_PWAIT = 6'b10_0000;
    localparam [2:0] LAST_CMD = 3'd5;

    reg  [5:0]             state_reg;
    reg  [2:0]             step_reg;
    reg                    chip_reg;
    reg  [1:0]             sect_reg;
    reg                    first_read_reg;
    reg                    prev_tog_reg;
    reg                    cyc_start;
    reg                    cyc_write;
    reg  [`PFE_ADDR_W-1:0] cyc_addr;
    reg  [7:0]             cyc_cmd;
    wire [`PFE_DATA_W-1:0] cyc_rdata;
    wire                   cyc_done;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [`PFE_ADDR_W-1:0] sector_addr;
        input [1:0] sel;
        begin
            if (sel == 2'd0) begin
                sector_addr = `PFE_SECT_BOOT;
            end else if (sel == 2'd1) begin
                sector_addr = `PFE_SECT_PARAM1;
            end else if (sel == 2'd2) begin
                sector_addr = `PFE_SECT_PARAM2;
            end else begin
                sector_addr = `PFE_SECT_MAIN;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // command step table
    // ----------------------------------------------------------------
    always @* begin
        cyc_write = 1'b1;
        cyc_addr  = `PFE_CMD_ADDR_A;
        cyc_cmd   = `PFE_CMD_UNLOCK_A;
        case (step_reg)
            3'd0: begin
                cyc_cmd = `PFE_CMD_UNLOCK_A;
            end
            3'd1: begin
                cyc_addr = `PFE_CMD_ADDR_B;
                cyc_cmd  = `PFE_CMD_UNLOCK_B;
            end
            3'd2: begin
                cyc_cmd = `PFE_CMD_ERASE_SETUP;
            end
            3'd3: begin
                cyc_cmd = `PFE_CMD_UNLOCK_A;
            end
            3'd4: begin
                cyc_addr = `PFE_CMD_ADDR_B;
                cyc_cmd  = `PFE_CMD_UNLOCK_B;
            end
            default: begin
                // chip erase at fixed address, sector erase at sector address [RULE2] [RULE3] [RULE9]
                cyc_addr = chip_reg ? `PFE_CMD_ADDR_A : sector_addr(sect_reg);
                // confirm code picks the erase scope [RULE4]
                cyc_cmd  = chip_reg ? `PFE_CMD_CHIP_ERASE : `PFE_CMD_SECT_ERASE;
            end
        endcase
        if (state_reg == ST_POLL1 || state_reg == ST_POLL2 || state_reg == ST_PWAIT) begin
            cyc_write = 1'b0;
            // polling address is fixed to the confirm address for the whole wait [RULE7]
            cyc_addr  = chip_reg ? `PFE_CMD_ADDR_A : sector_addr(sect_reg);
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign erase_ready = state_reg[0];

    always @(posedge clock) begin
        cyc_start  <= 1'b0;
        erase_done <= 1'b0;
        if (sys_rst) begin
            state_reg      <= ST_IDLE;
            step_reg       <= 3'd0;
            chip_reg       <= 1'b0;
            sect_reg       <= 2'd0;
            first_read_reg <= 1'b1;
            prev_tog_reg   <= 1'b0;
            erase_busy     <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (erase_start) begin
                        chip_reg   <= erase_chip;
                        sect_reg   <= sector_sel;
                        step_reg   <= 3'd0;
                        erase_busy <= 1'b1;
                        cyc_start  <= 1'b1;
                        state_reg  <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (step_reg == LAST_CMD) begin
                            first_read_reg <= 1'b1;
                            cyc_start      <= 1'b1;
                            state_reg      <= ST_POLL1;
                        end else begin
                            step_reg  <= step_reg + 3'd1;
                            cyc_start <= 1'b1;
                            state_reg <= ST_ISSUE;
                        end
                    end
                end
                ST_POLL1: begin
                    state_reg <= ST_PWAIT;
                end
                ST_PWAIT: begin
                    if (cyc_done) begin
                        state_reg <= ST_POLL2;
                    end
                end
                ST_POLL2: begin
                    // each read cycle toggles chip select and output enable [RULE5]
                    // only a change between reads means busy; level is not trusted [RULE6] [RULE10]
                    prev_tog_reg   <= cyc_rdata[`PFE_TOGGLE_BIT];
                    first_read_reg <= 1'b0;
                    if (!first_read_reg && cyc_rdata[`PFE_TOGGLE_BIT] == prev_tog_reg) begin
                        erase_busy <= 1'b0;
                        erase_done <= 1'b1;
                        state_reg  <= ST_IDLE;
                    end else begin
                        cyc_start <= 1'b1;
                        state_reg <= ST_POLL1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin cycle engine
    // ----------------------------------------------------------------
    pfe_bus_cycle u_cycle (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .start       (cyc_start),
        .is_write    (cyc_write),
        .addr_in     (cyc_addr),
        .data_in     ({8'h00, cyc_cmd}), // upper byte is ignored by the device [RULE8]
        .flash_dq_i  (flash_dq_i),
        .flash_addr  (flash_addr),
        .flash_dq_o  (flash_dq_o),
        .flash_dq_oe (flash_dq_oe),
        .flash_ce_n  (flash_ce_n),
        .flash_oe_n  (flash_oe_n),
        .flash_we_n  (flash_we_n),
        .read_data   (cyc_rdata),
        .done        (cyc_done)
    );

endmodule // pfe_erase_ctrl
`default_nettype wire

// ===== rtl/pfe_flash_regs.vh
// timing, command and address constants for the parallel flash erase sequencer
`ifndef PFE_FLASH_REGS_VH
`define PFE_FLASH_REGS_VH

// ----------------------------------------------------------------
// clock and pin timing
// ----------------------------------------------------------------
`define PFE_CLK_NS          50
`define PFE_T_WP_NS         70
`define PFE_T_WPH_NS        50
`define PFE_T_AS_NS         10
`define PFE_T_DH_NS         10
`define PFE_T_ACC_NS        120
`define PFE_T_OEHP_NS       150
`define PFE_WP_CYC          ((`PFE_T_WP_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)
`define PFE_WPH_CYC         ((`PFE_T_WPH_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)
`define PFE_AS_CYC          ((`PFE_T_AS_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)
`define PFE_DH_CYC          ((`PFE_T_DH_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)
`define PFE_ACC_CYC         ((`PFE_T_ACC_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)
`define PFE_OEHP_CYC        ((`PFE_T_OEHP_NS + `PFE_CLK_NS - 1) / `PFE_CLK_NS)

// ----------------------------------------------------------------
// command codes and addresses
// ----------------------------------------------------------------
`define PFE_ADDR_W          19
`define PFE_DATA_W          16
`define PFE_CMD_ADDR_A      19'h0_5555
`define PFE_CMD_ADDR_B      19'h0_2AAA
`define PFE_CMD_UNLOCK_A    8'hAA
`define PFE_CMD_UNLOCK_B    8'h55
`define PFE_CMD_ERASE_SETUP 8'h80
`define PFE_CMD_CHIP_ERASE  8'h10
`define PFE_CMD_SECT_ERASE  8'h30
`define PFE_TOGGLE_BIT      6

// sector select addresses, bottom-boot variant
`define PFE_SECT_BOOT       19'h0_2000
`define PFE_SECT_PARAM1     19'h0_4000
`define PFE_SECT_PARAM2     19'h0_6000
`define PFE_SECT_MAIN       19'h7_E000

`endif

// ===== rtl/pfe_bus_cycle.v
// one write or read cycle on the flash pins, timed from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "pfe_flash_regs.vh"

module pfe_bus_cycle (
    input  wire                    clock,
    input  wire                    sys_rst,
    input  wire                    start,
    input  wire                    is_write,
    input  wire [`PFE_ADDR_W-1:0]  addr_in,
    input  wire [`PFE_DATA_W-1:0]  data_in,
    input  wire [`PFE_DATA_W-1:0]  flash_dq_i,
    output reg  [`PFE_ADDR_W-1:0]  flash_addr,
    output reg  [`PFE_DATA_W-1:0]  flash_dq_o,
    output reg                     flash_dq_oe,
    output reg                     flash_ce_n,
    output reg                     flash_oe_n,
    output reg                     flash_we_n,
    output reg  [`PFE_DATA_W-1:0]  read_data,
    output reg                     done
);

    localparam [4:0] ST_IDLE  = 5'b0_0001;
    localparam [4:0] ST_SETUP = 5'b0_0010;
    localparam [4:0] ST_PULSE = 5'b0_0100;
    localparam [4:0] ST_HOLD  = 5'b0_1000;
    localparam [4:0] ST_GAP   = 5'b1_0000;
    // cycle counts are worked out as integers, then cut to the counter width on purpose
    localparam integer WP_I   = `PFE_WP_CYC;
    localparam integer ACC_I  = `PFE_ACC_CYC;
    localparam integer AS_I   = `PFE_AS_CYC;
    localparam integer DH_I   = `PFE_DH_CYC;
    localparam integer WPH_I  = `PFE_WPH_CYC;
    localparam integer OEHP_I = `PFE_OEHP_CYC;
    localparam [3:0] WP_CNT   = WP_I[3:0];
    localparam [3:0] ACC_CNT  = ACC_I[3:0];
    localparam [3:0] AS_CNT   = AS_I[3:0];
    localparam [3:0] DH_CNT   = DH_I[3:0];
    localparam [3:0] WPH_CNT  = WPH_I[3:0];
    localparam [3:0] OEHP_CNT = OEHP_I[3:0];

    reg [4:0] state_reg;
    reg [3:0] cnt_reg;
    reg       wr_reg;

    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    // the gap after a read is long enough for the toggling strobe high pulse
    always @(posedge clock) begin
        done <= 1'b0;
        if (sys_rst) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 4'h0;
            wr_reg      <= 1'b0;
            flash_addr  <= {`PFE_ADDR_W{1'b0}};
            flash_dq_o  <= {`PFE_DATA_W{1'b0}};
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            flash_oe_n  <= 1'b1;
            flash_we_n  <= 1'b1;
            read_data   <= {`PFE_DATA_W{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        wr_reg      <= is_write;
                        flash_addr  <= addr_in;
                        flash_dq_o  <= data_in;
                        flash_dq_oe <= is_write;
                        cnt_reg     <= AS_CNT;
                        state_reg   <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        flash_ce_n <= 1'b0;
                        // output enable stays high across the write strobe [RULE1]
                        flash_we_n <= ~wr_reg;
                        flash_oe_n <= wr_reg;
                        cnt_reg    <= wr_reg ? WP_CNT : ACC_CNT;
                        state_reg  <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        if (!wr_reg) begin
                            read_data <= flash_dq_i;
                        end
                        flash_we_n <= 1'b1;
                        flash_oe_n <= 1'b1;
                        cnt_reg    <= DH_CNT;
                        state_reg  <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        flash_ce_n  <= 1'b1;
                        flash_dq_oe <= 1'b0;
                        cnt_reg     <= wr_reg ? WPH_CNT : OEHP_CNT;
                        state_reg   <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (cnt_reg > 4'h1) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        done      <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // pfe_bus_cycle
`default_nettype wire

// ===== test/pfe_erase_ctrl_assertions.sv
// concurrent checks on the pins of the erase sequencer
`timescale 1ns/1ns
`default_nettype none

module pfe_erase_ctrl_assertions (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        erase_start,
    input wire logic        erase_chip,
    input wire logic [1:0]  sector_sel,
    input wire logic [18:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe,
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic        erase_ready,
    input wire logic        erase_busy,
    input wire logic        erase_done
);
    // ----------------------------------------------------------------
    // request capture and read counting
    // ----------------------------------------------------------------
    logic        chip_reg;
    logic [1:0]  sel_reg;
    logic [3:0]  rd_cnt_reg;
    logic        oe_n_reg;
    wire  [18:0] sect_addr = (sel_reg == 2'h0) ? 19'h0_2000 : (sel_reg == 2'h1) ? 19'h0_4000 :
                             (sel_reg == 2'h2) ? 19'h0_6000 : 19'h7_E000;

    always @(posedge clock) begin
        oe_n_reg <= flash_oe_n;
        if (sys_rst || (erase_start && erase_ready)) begin
            chip_reg   <= erase_chip;
            sel_reg    <= sector_sel;
            rd_cnt_reg <= 4'h0;
        end else if (oe_n_reg && !flash_oe_n && rd_cnt_reg != 4'hF) begin
            rd_cnt_reg <= rd_cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_oe_in_write;
        !flash_we_n |-> flash_oe_n && !flash_ce_n && flash_dq_oe;
    endproperty
    a_oe_in_write: assert property (p_oe_in_write) else $error("output enable low during write pulse");
    property p_upper_zero;
        flash_dq_oe |-> flash_dq_o[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper data byte not zero");
    property p_chip_addr;
        !flash_we_n && flash_dq_o[7:0] == 8'h10 |-> flash_addr == 19'h0_5555;
    endproperty
    a_chip_addr: assert property (p_chip_addr) else $error("chip erase confirm at wrong address");
    property p_sect_addr;
        !flash_we_n && flash_dq_o[7:0] == 8'h30 |-> flash_addr == sect_addr;
    endproperty
    a_sect_addr: assert property (p_sect_addr) else $error("sector confirm at wrong address");
    property p_confirm_code;
        !flash_we_n && (flash_dq_o[7:0] == 8'h10 || flash_dq_o[7:0] == 8'h30)
            |-> flash_dq_o[7:0] == (chip_reg ? 8'h10 : 8'h30);
    endproperty
    a_confirm_code: assert property (p_confirm_code) else $error("confirm code does not match request");
    property p_poll_addr;
        !flash_oe_n |-> flash_addr == (chip_reg ? 19'h0_5555 : sect_addr);
    endproperty
    a_poll_addr: assert property (p_poll_addr) else $error("polling address moved");
    property p_done_reads;
        erase_done |-> rd_cnt_reg >= 4'h2;
    endproperty
    a_done_reads: assert property (p_done_reads) else $error("done with fewer than two reads");
    property p_done_pulse;
        erase_done |=> !erase_done && !erase_busy && erase_ready;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse ending busy");
    property p_accept;
        erase_start && erase_ready |=> erase_busy && !erase_ready;
    endproperty
    a_accept: assert property (p_accept) else $error("request not accepted");
    property p_we_width;
        $fell(flash_we_n) |-> !flash_we_n [*2] ##1 flash_we_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write pulse not two cycles");
    property p_oe_gap;
        $rose(flash_oe_n) |-> flash_oe_n [*3];
    endproperty
    a_oe_gap: assert property (p_oe_gap) else $error("output enable high pulse too short");
endmodule // pfe_erase_ctrl_assertions

bind pfe_erase_ctrl pfe_erase_ctrl_assertions u_chk (.clock, .sys_rst, .erase_start, .erase_chip, .sector_sel,
    .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .erase_ready, .erase_busy,
    .erase_done);

`default_nettype wire

// ===== test/pfe_flash_model.sv
// behavioural flash device answering erase commands with toggle status
`timescale 1ns/1ns
`default_nettype none

module pfe_flash_model (
    input  wire logic [18:0] addr,
    input  wire logic [15:0] dq_o,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  busy_len,
    input  wire logic        start_lvl,
    output var  logic [15:0] dq_i,
    output var  int          wr_total,
    output var  int          rd_busy,
    output var  logic [18:0] conf_addr,
    output var  logic [7:0]  conf_data,
    output var  logic        seq_bad,
    output var  logic        addr_var
);
    logic [7:0]  left_reg = 8'h00;
    logic        tog_reg  = 1'b0;
    logic [15:0] word_reg = 16'h0000;
    wire         rd_act   = !ce_n && !oe_n;
    int          idx;

    initial begin
        wr_total = 0;
        rd_busy = 0;
        conf_addr = 19'h0_5555;
        conf_data = 8'h00;
        seq_bad = 1'b0;
        addr_var = 1'b0;
    end

    // one process owns the array state: a read starts when either enable falls with the other low
    // writes land on the rising strobe; only the low byte is decoded
    always @(posedge we_n or posedge rd_act) begin
        if (rd_act) begin
            if (addr !== conf_addr)
                addr_var <= 1'b1;
            if (left_reg != 8'h00) begin
                word_reg <= {9'h000, tog_reg, 6'h00};
                tog_reg  <= ~tog_reg;
                left_reg <= left_reg - 8'h01;
                rd_busy  <= rd_busy + 1;
            end else begin
                word_reg <= 16'hFFFF;
            end
        end else if (!ce_n) begin
            idx = wr_total % 6;
            if (dq_o[7:0] == 8'h10 || dq_o[7:0] == 8'h30) begin
                conf_addr <= addr;
                conf_data <= dq_o[7:0];
                left_reg  <= busy_len;
                tog_reg   <= start_lvl;
                if (idx != 5)
                    seq_bad <= 1'b1;
            end else if (addr != ((idx % 3 == 1) ? 19'h0_2AAA : 19'h0_5555) ||
                         dq_o[7:0] != ((idx == 2) ? 8'h80 : (idx % 3 == 1) ? 8'h55 : 8'hAA)) begin
                seq_bad <= 1'b1;
            end
            wr_total <= wr_total + 1;
        end
    end

    // a released bus must not look like it still holds the last word
    always @* dq_i = rd_act ? word_reg : ~word_reg;
endmodule // pfe_flash_model

`default_nettype wire

// ===== test/parallel_flash_erase_and_poll_tb.sv
// self-checking testbench for the erase sequencer against a flash model
`timescale 1ns/1ns
`default_nettype none

module parallel_flash_erase_and_poll_tb;
    logic        clock       = 1'b0;
    logic        sys_rst     = 1'b1;
    logic        erase_start = 1'b0;
    logic        erase_chip  = 1'b0;
    logic [1:0]  sector_sel  = 2'h0;
    logic [7:0]  busy_len    = 8'h00;
    logic        start_lvl   = 1'b0;
    wire  [15:0] flash_dq_i;
    wire  [15:0] flash_dq_o;
    wire  [18:0] flash_addr;
    wire         flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, erase_ready, erase_busy, erase_done;
    int          wr_total, rd_busy;
    logic [18:0] conf_addr;
    logic [7:0]  conf_data;
    logic        seq_bad, addr_var;
    int          err_count = 0;
    int          tests_run = 0;

    always #25 clock = ~clock;

    pfe_erase_ctrl u_dut (.clock(clock), .sys_rst(sys_rst), .erase_start(erase_start), .erase_chip(erase_chip),
        .sector_sel(sector_sel), .flash_dq_i(flash_dq_i), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .erase_ready(erase_ready), .erase_busy(erase_busy), .erase_done(erase_done));

    pfe_flash_model u_flash (.addr(flash_addr), .dq_o(flash_dq_o), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
        .we_n(flash_we_n), .busy_len(busy_len), .start_lvl(start_lvl), .dq_i(flash_dq_i), .wr_total(wr_total),
        .rd_busy(rd_busy), .conf_addr(conf_addr), .conf_data(conf_data), .seq_bad(seq_bad), .addr_var(addr_var));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        check({flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, erase_busy, erase_done, erase_ready}, 7'h71);
        $display("test reset values done");
    endtask

    // one full erase; optionally a second request while busy, which must be ignored
    task automatic t_erase(input logic chip, input logic [1:0] sel, input logic [7:0] blen, input logic lvl,
                           input logic refuse);
        int          w0;
        int          r0;
        int          n;
        logic [18:0] exp_addr;
        w0 = wr_total;
        r0 = rd_busy;
        n = 0;
        exp_addr = chip ? 19'h0_5555 : (sel == 2'h0) ? 19'h0_2000 : (sel == 2'h1) ? 19'h0_4000 :
                   (sel == 2'h2) ? 19'h0_6000 : 19'h7_E000;
        busy_len = blen;
        start_lvl = lvl;
        erase_chip = chip;
        sector_sel = sel;
        erase_start = 1'b1;
        @(negedge clock);
        erase_start = 1'b0;
        check(erase_busy, 1'b1);
        if (refuse) begin
            repeat (10) @(negedge clock);
            erase_chip = ~chip;
            sector_sel = ~sel;
            erase_start = 1'b1;
            check(erase_ready, 1'b0);
            @(negedge clock);
            erase_start = 1'b0;
        end
        while (erase_done !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        check(n < 3000, 1'b1);
        @(negedge clock);
        check({erase_busy, erase_ready}, 2'h1);
        check(wr_total - w0, 32'h0000_0006);
        check(seq_bad, 1'b0);
        check(conf_addr, exp_addr);
        check(conf_data, chip ? 8'h10 : 8'h30);
        check(rd_busy - r0, blen);
        check(addr_var, 1'b0);
        $display("test erase chip=%0d sector=%0d done", chip, sel);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clock);
        t_reset();
        sys_rst = 1'b0;
        @(negedge clock);
        t_erase(1'b1, 2'h0, 8'h00, 1'b0, 1'b0);
        t_erase(1'b1, 2'h0, 8'h07, 1'b1, 1'b1);
        for (int s = 0; s < 4; s++)
            t_erase(1'b0, s[1:0], 8'h03 + 8'(s), s[0], 1'b0);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule // parallel_flash_erase_and_poll_tb

`default_nettype wire
